// [verilog/dgc_defs.vh]
`ifndef DGC_DEFS_VH
`define DGC_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DGC_ADDR_SLAVE_SEL 8'h00
`define DGC_ADDR_RESET_CONTROL 8'h01
`define DGC_ADDR_GEN_CFG 8'h02
`define DGC_ADDR_DEV_STS 8'h04

// ----------------------------------------
// slave address select fields
// ----------------------------------------
`define DGC_SAS_OVR_BIT 0
`define DGC_SAS_ADDR_MSB 7
`define DGC_SAS_ADDR_LSB 1
`define DGC_SAS_OVR_RST 1'b0

// ----------------------------------------
// reset control fields
// ----------------------------------------
`define DGC_RST_KEEP_BIT 0
`define DGC_RST_FULL_BIT 1
`define DGC_RST_RELOAD_BIT 2
`define DGC_RST_SPARE_BIT 5
`define DGC_RST_SPARE_RST 1'b0

// ----------------------------------------
// general configuration fields
// ----------------------------------------
`define DGC_GCFG_PAR_BIT 1
`define DGC_GCFG_SLEEP_BIT 2
`define DGC_GCFG_OEN_BIT 3
`define DGC_GCFG_MODE_BIT 4
`define DGC_GCFG_RST 4'hf

// ----------------------------------------
// device status fields
// ----------------------------------------
`define DGC_STS_CKSUM_BIT 7
`define DGC_STS_DONE_BIT 6
`define DGC_STS_LOW_RST 6'h02

// ----------------------------------------
// timing counts
// ----------------------------------------
`define DGC_ROM_LOAD_CYCLES 64

`endif

// [verilog/dgc_rom_loader.v]
`timescale 1ns/1ps
`include "dgc_defs.vh"

module dgc_rom_loader #(
    parameter LOAD_CYCLES = `DGC_ROM_LOAD_CYCLES,
    parameter CNT_W = 16
) (
    input wire clock,
    input wire resetn,
    input wire start,
    output wire busy,
    output wire done
);

    localparam [1:0] ST_LOAD = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;
    localparam integer LAST_INT = LOAD_CYCLES - 1;
    localparam [CNT_W-1:0] LAST = LAST_INT[CNT_W-1:0];

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [CNT_W-1:0] cnt_reg;
    reg [CNT_W-1:0] cnt_next;

    // ----------------------------------------
    // load sequencer, starts itself at power-up
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_LOAD: begin
                if (start) begin
                    cnt_next = {CNT_W{1'b0}};
                end else if (cnt_reg == LAST) begin
                    state_next = ST_DONE;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_DONE: begin
                if (start) begin
                    state_next = ST_LOAD;
                    cnt_next = {CNT_W{1'b0}};
                end
            end
            default: begin
                state_next = ST_LOAD;
                cnt_next = {CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_LOAD;
            cnt_reg <= {CNT_W{1'b0}};
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign busy = state_reg[0];
    assign done = state_reg[1];

endmodule // dgc_rom_loader

// [verilog/dgc_global_ctrl.v]
`timescale 1ns/1ps
`include "dgc_defs.vh"

module dgc_global_ctrl #(
    parameter NUM_TX = 2,
    parameter NUM_RX = 4,
    parameter LOAD_CYCLES = `DGC_ROM_LOAD_CYCLES
) (
    input wire clock,
    input wire resetn,
    input wire [6:0] strap_addr,
    input wire [NUM_RX-1:0] rx_lock,
    input wire [NUM_TX*NUM_RX-1:0] tx_rx_assign,
    input wire cfg_cksum_ok,
    input wire loc_req,
    input wire loc_wr,
    input wire [7:0] loc_addr,
    input wire [7:0] loc_wdata,
    output reg [7:0] loc_rdata,
    output reg loc_ack,
    input wire rem_req,
    input wire rem_wr,
    input wire [7:0] rem_addr,
    input wire [7:0] rem_wdata,
    output wire rem_ready,
    output reg [7:0] rem_rdata,
    output reg rem_ack,
    output wire [6:0] active_slave_addr,
    output reg full_logic_reset,
    output reg logic_reset_keep_regs,
    output wire rom_load_busy,
    output wire parity_check_en,
    output reg [NUM_TX-1:0] tx_hiz,
    output reg [NUM_TX-1:0] tx_force_hs0,
    output reg [NUM_TX-1:0] tx_force_lp11
);

    reg [6:0] strap_s1_reg;
    reg [6:0] strap_s2_reg;
    reg [6:0] strap_cap_reg;
    reg [NUM_RX-1:0] lock_s1_reg;
    reg [NUM_RX-1:0] lock_s2_reg;
    reg [6:0] addr_field_reg;
    reg override_reg;
    reg spare_reg;
    reg [3:0] gcfg_reg;
    reg reload_reg;
    reg [7:0] rd_mux;
    wire init_done;
    wire take;
    wire wr;
    wire [7:0] addr;
    wire [7:0] wdata;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strap_s1_reg <= 7'h00;
            strap_s2_reg <= 7'h00;
            lock_s1_reg <= {NUM_RX{1'b0}};
            lock_s2_reg <= {NUM_RX{1'b0}};
            strap_cap_reg <= 7'h00;
        end else begin
            strap_s1_reg <= strap_addr;
            strap_s2_reg <= strap_s1_reg;
            lock_s1_reg <= rx_lock;
            lock_s2_reg <= lock_s1_reg;
            if (rom_load_busy) begin
                strap_cap_reg <= strap_s2_reg;
            end
        end
    end

    // ----------------------------------------
    // access arbitration, local first
    // ----------------------------------------
    assign rem_ready = !loc_req;
    assign take = loc_req || rem_req;
    assign wr = loc_req ? loc_wr : rem_wr;
    assign addr = loc_req ? loc_addr : rem_addr;
    assign wdata = loc_req ? loc_wdata : rem_wdata;

    assign active_slave_addr = override_reg ? addr_field_reg : strap_cap_reg;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            addr_field_reg <= 7'h00;
            override_reg <= `DGC_SAS_OVR_RST;
            spare_reg <= `DGC_RST_SPARE_RST;
            gcfg_reg <= `DGC_GCFG_RST;
            reload_reg <= 1'b0;
            full_logic_reset <= 1'b0;
            logic_reset_keep_regs <= 1'b0;
        end else begin
            reload_reg <= 1'b0;
            full_logic_reset <= 1'b0;
            logic_reset_keep_regs <= 1'b0;
            if (full_logic_reset) begin
                addr_field_reg <= 7'h00;
                override_reg <= `DGC_SAS_OVR_RST;
                spare_reg <= `DGC_RST_SPARE_RST;
                gcfg_reg <= `DGC_GCFG_RST;
            end else if (take && wr) begin
                case (addr)
                    `DGC_ADDR_SLAVE_SEL: begin
                        override_reg <= wdata[`DGC_SAS_OVR_BIT];
                        if (wdata[`DGC_SAS_OVR_BIT]) begin
                            addr_field_reg <= wdata[`DGC_SAS_ADDR_MSB:`DGC_SAS_ADDR_LSB];
                        end
                    end
                    `DGC_ADDR_RESET_CONTROL: begin
                        spare_reg <= wdata[`DGC_RST_SPARE_BIT];
                        reload_reg <= wdata[`DGC_RST_RELOAD_BIT];
                        full_logic_reset <= wdata[`DGC_RST_FULL_BIT];
                        logic_reset_keep_regs <= wdata[`DGC_RST_KEEP_BIT];
                    end
                    `DGC_ADDR_GEN_CFG: begin
                        gcfg_reg <= wdata[`DGC_GCFG_MODE_BIT:`DGC_GCFG_PAR_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // read mux, reserved bits zero except status bits 5:0, which read 6'h02
    // ----------------------------------------
    always @* begin
        case (addr)
            `DGC_ADDR_SLAVE_SEL: rd_mux = {active_slave_addr, override_reg};
            `DGC_ADDR_RESET_CONTROL: rd_mux = {2'b00, spare_reg, 2'b00, reload_reg, full_logic_reset,
                                           logic_reset_keep_regs};
            `DGC_ADDR_GEN_CFG: rd_mux = {3'b000, gcfg_reg, 1'b0};
            `DGC_ADDR_DEV_STS: rd_mux = {cfg_cksum_ok, init_done, `DGC_STS_LOW_RST};
            default: rd_mux = 8'h00;
        endcase
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            loc_rdata <= 8'h00;
            rem_rdata <= 8'h00;
            loc_ack <= 1'b0;
            rem_ack <= 1'b0;
        end else begin
            loc_ack <= loc_req;
            rem_ack <= rem_req && !loc_req;
            if (loc_req && !loc_wr) begin
                loc_rdata <= rd_mux;
            end
            if (rem_req && !loc_req && !rem_wr) begin
                rem_rdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // rom load sequencer
    // ----------------------------------------
    dgc_rom_loader #(
        .LOAD_CYCLES(LOAD_CYCLES)
    ) u_loader (
        .clock(clock),
        .resetn(resetn),
        .start(reload_reg || full_logic_reset),
        .busy(rom_load_busy),
        .done(init_done)
    );

    assign parity_check_en = gcfg_reg[`DGC_GCFG_PAR_BIT - 1];

    // ----------------------------------------
    // tx port output state per port
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TX; gi = gi + 1) begin : g_tx
            wire nolock;
            assign nolock = ~|(lock_s2_reg & tx_rx_assign[gi*NUM_RX +: NUM_RX]);
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    tx_hiz[gi] <= 1'b0;
                    tx_force_hs0[gi] <= 1'b0;
                    tx_force_lp11[gi] <= 1'b0;
                end else begin
                    tx_hiz[gi] <= 1'b0;
                    tx_force_hs0[gi] <= 1'b0;
                    tx_force_lp11[gi] <= 1'b0;
                    if (nolock && !gcfg_reg[`DGC_GCFG_MODE_BIT - 1]) begin
                        tx_hiz[gi] <= 1'b1;
                    end else if (gcfg_reg[`DGC_GCFG_SLEEP_BIT - 1] && !gcfg_reg[`DGC_GCFG_OEN_BIT - 1]) begin
                        tx_hiz[gi] <= 1'b1;
                    end else if (nolock && !gcfg_reg[`DGC_GCFG_SLEEP_BIT - 1]) begin
                        tx_force_hs0[gi] <= 1'b1;
                    end else if (nolock) begin
                        tx_force_lp11[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule // dgc_global_ctrl

// [sim/dgc_global_ctrl_properties.sv]
`timescale 1ns/1ps
module dgc_chk #(
    parameter NUM_TX = 2
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic loc_req,
    input wire logic loc_wr,
    input wire logic [7:0] loc_addr,
    input wire logic [7:0] loc_wdata,
    input wire logic loc_ack,
    input wire logic rem_req,
    input wire logic rem_ready,
    input wire logic rem_ack,
    input wire logic [6:0] active_slave_addr,
    input wire logic full_logic_reset,
    input wire logic logic_reset_keep_regs,
    input wire logic rom_load_busy,
    input wire logic parity_check_en,
    input wire logic [NUM_TX-1:0] tx_hiz,
    input wire logic [NUM_TX-1:0] tx_force_hs0,
    input wire logic [NUM_TX-1:0] tx_force_lp11
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire lw = loc_req && loc_wr;
    wire rw = lw && loc_addr == 8'h01;

    a_loc_ack_exact: assert property (1'b1 |=> loc_ack == $past(loc_req))
        else $error("local ack does not follow request");
    a_rem_ack_exact: assert property (1'b1 |=> rem_ack == $past(rem_req && !loc_req))
        else $error("remote ack does not follow taken request");
    a_rem_yields: assert property (loc_req |-> !rem_ready)
        else $error("remote ready while local busy");
    a_ovr_addr_set: assert property (lw && loc_addr == 8'h00 && loc_wdata[0] |=>
        active_slave_addr == $past(loc_wdata[7:1]))
        else $error("override address not active");
    a_parity_follow: assert property (lw && loc_addr == 8'h02 |=>
        parity_check_en == $past(loc_wdata[1]))
        else $error("parity enable wrong");
    a_full_rst_pulse: assert property (rw && loc_wdata[1] |=>
        full_logic_reset ##1 (!full_logic_reset && parity_check_en))
        else $error("full reset pulse or defaults wrong");
    a_keep_rst_pulse: assert property (rw && loc_wdata[0] |=>
        logic_reset_keep_regs ##1 !logic_reset_keep_regs)
        else $error("keep reset pulse wrong");
    a_reload_busy: assert property (rw && loc_wdata[2] |-> ##[1:3] rom_load_busy)
        else $error("reload did not start");
    a_tx_one_state: assert property (((tx_hiz & tx_force_hs0) | (tx_hiz & tx_force_lp11)
        | (tx_force_hs0 & tx_force_lp11)) == '0)
        else $error("two tx states at once");
endmodule // dgc_chk

bind dgc_global_ctrl dgc_chk #(.NUM_TX(NUM_TX)) chk (.clock(clock), .resetn(resetn), .loc_req(loc_req),
    .loc_wr(loc_wr), .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_ack(loc_ack), .rem_req(rem_req),
    .rem_ready(rem_ready), .rem_ack(rem_ack), .active_slave_addr(active_slave_addr),
    .full_logic_reset(full_logic_reset), .logic_reset_keep_regs(logic_reset_keep_regs),
    .rom_load_busy(rom_load_busy), .parity_check_en(parity_check_en), .tx_hiz(tx_hiz),
    .tx_force_hs0(tx_force_hs0), .tx_force_lp11(tx_force_lp11));

// [sim/dgc_remote_master.sv]
`timescale 1ns/1ps
module dgc_remote_master (
    input wire logic clock,
    output logic rem_req,
    output logic rem_wr,
    output logic [7:0] rem_addr,
    output logic [7:0] rem_wdata,
    input wire logic rem_ready,
    input wire logic [7:0] rem_rdata,
    input wire logic rem_ack
);
    initial begin
        rem_req = 1'b0;
        rem_wr = 1'b0;
        rem_addr = 8'h00;
        rem_wdata = 8'h00;
    end
    // call at a falling edge; gap idles first
    task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap,
              output logic [7:0] q, output logic k);
        begin
            repeat (gap) @(negedge clock);
            rem_req = 1'b1;
            rem_wr = wr;
            rem_addr = a;
            rem_wdata = d;
            @(posedge clock);
            while (!rem_ready) @(posedge clock);
            @(negedge clock);
            rem_req = 1'b0;
            rem_addr = ~a;
            rem_wdata = ~d;
            q = rem_rdata;
            k = rem_ack;
            @(negedge clock);
        end
    endtask
endmodule // dgc_remote_master

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic clock, resetn, cfg_cksum_ok, loc_req, loc_wr, loc_ack, rem_req, rem_wr, rem_ready, rem_ack, k;
    logic full_logic_reset, logic_reset_keep_regs, rom_load_busy, parity_check_en;
    logic [6:0] strap_addr, active_slave_addr;
    logic [3:0] rx_lock;
    logic [7:0] tx_rx_assign, loc_addr, loc_wdata, loc_rdata, rem_addr, rem_wdata, rem_rdata, q, p;
    logic [1:0] tx_hiz, tx_force_hs0, tx_force_lp11;
    int fails = 0;
    int compares = 0;

    dgc_global_ctrl #(.LOAD_CYCLES(4)) uut (.clock(clock), .resetn(resetn), .strap_addr(strap_addr),
        .rx_lock(rx_lock), .tx_rx_assign(tx_rx_assign), .cfg_cksum_ok(cfg_cksum_ok), .loc_req(loc_req),
        .loc_wr(loc_wr), .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_rdata(loc_rdata),
        .loc_ack(loc_ack), .rem_req(rem_req), .rem_wr(rem_wr), .rem_addr(rem_addr), .rem_wdata(rem_wdata),
        .rem_ready(rem_ready), .rem_rdata(rem_rdata), .rem_ack(rem_ack),
        .active_slave_addr(active_slave_addr), .full_logic_reset(full_logic_reset),
        .logic_reset_keep_regs(logic_reset_keep_regs), .rom_load_busy(rom_load_busy),
        .parity_check_en(parity_check_en), .tx_hiz(tx_hiz), .tx_force_hs0(tx_force_hs0),
        .tx_force_lp11(tx_force_lp11));
    dgc_remote_master rm (.clock(clock), .rem_req(rem_req), .rem_wr(rem_wr), .rem_addr(rem_addr),
        .rem_wdata(rem_wdata), .rem_ready(rem_ready), .rem_rdata(rem_rdata), .rem_ack(rem_ack));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        begin
            compares++;
            if (s !== e) begin
                fails++;
                $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares=%0d fails=%0d", compares, fails);
            if (fails == 0 && compares > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    task acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        begin
            loc_req = 1'b1;
            loc_wr = wr;
            loc_addr = a;
            loc_wdata = d;
            @(negedge clock);
            loc_req = 1'b0;
            chk({7'h00, loc_ack}, 8'h01);
            r = loc_rdata;
            @(negedge clock);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d, q);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        begin
            acc(1'b0, a, 8'h00, q);
            chk(q, e);
        end
    endtask
    // poll status until init done
    task wait_init;
        begin
            repeat (3) @(negedge clock);
            q = 8'h00;
            for (int i = 0; i < 40 && q[6] !== 1'b1; i++) acc(1'b0, 8'h04, 8'h00, q);
            chk(q, 8'hc2);
        end
    endtask
    task txc(input logic [3:0] l, input logic [7:0] c, input logic [7:0] e);
        begin
            rx_lock = l;
            wr(8'h02, c);
            repeat (4) @(negedge clock);
            chk({1'b0, parity_check_en, tx_hiz, tx_force_hs0, tx_force_lp11}, e);
        end
    endtask

    initial begin
        resetn = 1'b0;
        strap_addr = 7'h3a;
        rx_lock = 4'h0;
        tx_rx_assign = 8'h21;
        cfg_cksum_ok = 1'b1;
        loc_req = 1'b0;
        loc_wr = 1'b0;
        loc_addr = 8'h00;
        loc_wdata = 8'h00;
        q = 8'h00;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        wait_init();
        rd(8'h02, 8'h1e);
        rd(8'h00, 8'h74);
        rd(8'h01, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h00, 8'ha4);
        rd(8'h00, 8'h74);
        wr(8'h00, 8'ha5);
        rd(8'h00, 8'ha5);
        chk({1'b0, active_slave_addr}, 8'h52);
        txc(4'h0, 8'h00, 8'h30);
        txc(4'h1, 8'h00, 8'h20);
        txc(4'h0, 8'h10, 8'h0c);
        txc(4'h0, 8'h14, 8'h30);
        txc(4'h1, 8'h14, 8'h30);
        txc(4'h0, 8'h1e, 8'h43);
        txc(4'h1, 8'h1e, 8'h42);
        txc(4'h1, 8'h1c, 8'h02);
        fork
            acc(1'b0, 8'h02, 8'h00, p);
            rm.xfer(1'b1, 8'h02, 8'h1e, 0, q, k);
        join
        chk(p, 8'h1c);
        rm.xfer(1'b0, 8'h02, 8'h00, 3, q, k);
        chk({k, q[6:0]}, 8'h9e);
        wr(8'h01, 8'h01);
        rd(8'h02, 8'h1e);
        rd(8'h01, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h01, 8'h02);
        wait_init();
        rd(8'h02, 8'h1e);
        rd(8'h00, 8'h74);
        wr(8'h01, 8'h04);
        chk({7'h00, rom_load_busy}, 8'h01);
        wait_init();
        rd(8'h01, 8'h00);
        tally_and_finish();
    end
    initial begin
        #50000;
        fails++;
        tally_and_finish();
    end
endmodule // testbench
